// file: hw/fcq_consts.svh
// Offsets, command codes, field positions, reset values and timing counts of the command block.
`ifndef FCQ_CONSTS_SVH
`define FCQ_CONSTS_SVH

// Command codes seen on the low byte of a parallel bus write.
`define FCQ_CMD_READ_ARRAY    8'hFF
`define FCQ_CMD_READ_STATUS   8'h70
`define FCQ_CMD_CLEAR_STATUS  8'h50
`define FCQ_CMD_PROG_SETUP    8'h40
`define FCQ_CMD_SUSPEND       8'hB0
`define FCQ_CMD_RESUME        8'hD0
`define FCQ_CMD_CFG_SETUP     8'h60
`define FCQ_CMD_CFG_CONFIRM   8'h03
`define FCQ_CMD_PARAM_QUERY   8'h98

// Flash status byte fields.
`define FCQ_STS_READY_BIT     7
`define FCQ_STS_PROG_ERR_BIT  4
`define FCQ_STS_SUSP_BIT      2

// Burst configuration word: bit 15 high selects asynchronous reads.
`define FCQ_CFG_ASYNC_BIT     15
`define FCQ_CFG_RESET         16'hFFFF

// Query map offsets.
`define FCQ_QRY_MFR_ID        8'h00
`define FCQ_QRY_DEV_ID        8'h01
`define FCQ_QRY_IDSTR         8'h10
`define FCQ_QRY_PRI_PTR       8'h15
`define FCQ_QRY_ALT_PTR       8'h19
`define FCQ_QRY_PRI_TABLE     8'h35

// Register byte offsets on the AXI4-Lite slave.
`define FCQ_REG_EVENTS        12'h000
`define FCQ_REG_MASK          12'h004
`define FCQ_REG_CONFIG        12'h008
`define FCQ_REG_STATE         12'h00C
`define FCQ_REG_CTRL          12'h010

// Event bit positions in the sticky event and mask registers.
`define FCQ_EV_SUSPENDED      0
`define FCQ_EV_PROG_DONE      1
`define FCQ_EV_PROG_ERR       2
`define FCQ_EV_CFG_LOADED     3
`define FCQ_EV_WIDTH          4

// Timing: clock period and operation times, in nanoseconds.
`define FCQ_CLK_PERIOD_NS     40
`define FCQ_PROG_TIME_NS      16000
`define FCQ_SUSP_TIME_NS      200
`define FCQ_PROG_CYCLES       ((`FCQ_PROG_TIME_NS + `FCQ_CLK_PERIOD_NS - 1) / `FCQ_CLK_PERIOD_NS)
`define FCQ_SUSP_CYCLES       (`FCQ_SUSP_TIME_NS / `FCQ_CLK_PERIOD_NS)

// AXI responses.
`define FCQ_RESP_OKAY         2'b00
`define FCQ_RESP_DECERR       2'b11

`endif

// file: hw/fcq_pkg.sv
// Types shared by the command block files.
package fcq_pkg;

  // What a parallel bus read returns.
  typedef enum logic [1:0] {
    FCQ_MODE_ARRAY  = 2'b00,
    FCQ_MODE_STATUS = 2'b01,
    FCQ_MODE_QUERY  = 2'b10
  } fcq_mode_t;

  // Second cycle of a two-write command that is pending.
  typedef enum logic [1:0] {
    FCQ_STG_NONE = 2'b00,
    FCQ_STG_PROG = 2'b01,
    FCQ_STG_CFG  = 2'b10
  } fcq_stage_t;

  // Program engine states.
  typedef enum logic [1:0] {
    FCQ_PRG_IDLE       = 2'b00,
    FCQ_PRG_BUSY       = 2'b01,
    FCQ_PRG_SUSPENDING = 2'b10,
    FCQ_PRG_SUSPENDED  = 2'b11
  } fcq_prog_t;

endpackage

// file: hw/fcq_query_rom.sv
// Parameter query structure: offset in, query word out.
`timescale 1ns/1ns
`default_nettype none
`include "fcq_consts.svh"

module fcq_query_rom #(
  parameter logic [15:0] MFR_ID = 16'h00A5,  // Arbitrary value.
  parameter logic [15:0] DEV_ID = 16'h1234   // Arbitrary value.
) (
  input  wire logic [7:0]  offset,
  output logic      [31:0] qdata
);

  logic [7:0] qbyte;

  // Byte entries; everything not listed reads as zero.
  always_comb begin
    case (offset)
      `FCQ_QRY_IDSTR:         qbyte = 8'h51;
      `FCQ_QRY_IDSTR + 8'h01: qbyte = 8'h52;
      `FCQ_QRY_IDSTR + 8'h02: qbyte = 8'h59;
      `FCQ_QRY_IDSTR + 8'h03: qbyte = 8'h03;
      `FCQ_QRY_PRI_PTR:       qbyte = `FCQ_QRY_PRI_TABLE;
      `FCQ_QRY_ALT_PTR:       qbyte = 8'h00;
      `FCQ_QRY_PRI_TABLE:     qbyte = 8'h50;
      default:                qbyte = 8'h00;
    endcase
  end

  // Identification codes are 16 bits wide; every other entry is a byte on the low lines.
  assign qdata = (offset == `FCQ_QRY_MFR_ID) ? {16'h0000, MFR_ID} :
                 (offset == `FCQ_QRY_DEV_ID) ? {16'h0000, DEV_ID} :
                 {24'h00_0000, qbyte};

endmodule
`default_nettype wire

// file: hw/fcq_top.sv
// Flash command interpreter with program suspend, burst configuration and query mode.
//
// Summary of operation
// - Suspend code then read-status code accepted; status register is shown afterwards.
// - When ready, status bit 2 shows suspension; zero means program already finished.
// - While suspended, read-array code gives array data on reads of other blocks.
// - Resume code restarts suspended programming; without suspension it changes nothing.
// - After resume the program finishes as if no suspend had been received.
// - Setup code then confirm code loads configuration word from address lines 15-0.
// - After reset the device reads asynchronously, configuration bit 15 set.
// - Configuration bit 15 written to zero selects synchronous burst reads.
// - Query code enters query mode; reads return the parameter structure.
// - Identification string section starts at query offset 10h.
// - Query offset 15h holds the primary extended table pointer.
// - Query offset 19h holds the alternate extended table pointer.
// - Query bytes sit on data lines 7-0; lines 31-8 read zero.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "fcq_consts.svh"

module fcq_top (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // AXI4-Lite register slave.
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic      [1:0]  S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic      [31:0] S_AXI_RDATA,
  output logic      [1:0]  S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Parallel flash bus, driven by controller logic on the same clock.
  input  wire logic        BUS_WE,
  input  wire logic        BUS_RE,
  input  wire logic [15:0] BUS_ADDR,
  input  wire logic [31:0] BUS_WDATA,
  output logic      [31:0] BUS_RDATA,
  output logic             BUS_RVALID,
  // Status outputs.
  output logic             SYNC_BURST,
  output logic             IRQ
);

  localparam logic [9:0] PROG_CYC = 10'(`FCQ_PROG_CYCLES);
  localparam logic [2:0] SUSP_CYC = 3'(`FCQ_SUSP_CYCLES);

  fcq_pkg::fcq_mode_t  mode_ff;
  fcq_pkg::fcq_mode_t  nxt_mode;
  fcq_pkg::fcq_stage_t stage_ff;
  fcq_pkg::fcq_stage_t nxt_stage;
  fcq_pkg::fcq_prog_t  prog_ff;
  fcq_pkg::fcq_prog_t  nxt_prog;
  logic [9:0]          cnt_ff;
  logic [9:0]          nxt_cnt;
  logic [2:0]          scnt_ff;
  logic [2:0]          nxt_scnt;
  logic [3:0]          paddr_ff;
  logic [3:0]          nxt_paddr;
  logic [31:0]         pdata_ff;
  logic [31:0]         nxt_pdata;
  logic [15:0]         cfg_ff;
  logic [15:0]         nxt_cfg;
  logic                err_ff;
  logic                nxt_err;
  logic [31:0]         mem_ff [16];
  logic                mem_we;
  logic [`FCQ_EV_WIDTH-1:0] ev;
  logic [7:0]          cmd;
  logic                prog_bad;
  logic [7:0]          flash_sts;
  logic [31:0]         qdata;
  logic [31:0]         rd_sel;
  logic [31:0]         bus_rdata_ff;
  logic                bus_rvalid_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Flash status byte and bus read path.

  // Ready while no program runs or once it is parked; suspended only when parked.
  assign flash_sts = {(prog_ff == fcq_pkg::FCQ_PRG_IDLE) ||
                        (prog_ff == fcq_pkg::FCQ_PRG_SUSPENDED),
                      2'b00, err_ff, 1'b0,
                      prog_ff == fcq_pkg::FCQ_PRG_SUSPENDED,
                      2'b00};

  fcq_query_rom u_rom (
    .offset (BUS_ADDR[7:0]),
    .qdata  (qdata)
  );

  // The array keeps its old word until a program really ends, so reads while parked see it.
  assign rd_sel = (mode_ff == fcq_pkg::FCQ_MODE_QUERY)  ? qdata :
                  (mode_ff == fcq_pkg::FCQ_MODE_STATUS) ? {24'h00_0000, flash_sts} :
                  mem_ff[BUS_ADDR[3:0]];

  // Read data is registered; valid follows the read strobe by one cycle.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      bus_rdata_ff  <= 32'h0000_0000;
      bus_rvalid_ff <= 1'b0;
    end else begin
      bus_rvalid_ff <= BUS_RE;
      if (BUS_RE) begin
        bus_rdata_ff <= rd_sel;
      end
    end
  end

  assign BUS_RDATA  = bus_rdata_ff;
  assign BUS_RVALID = bus_rvalid_ff;
  assign SYNC_BURST = ~cfg_ff[`FCQ_CFG_ASYNC_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Command interpreter and program engine.

  logic       wp_ff;

  assign cmd      = BUS_WDATA[7:0];
  // Flash cells only clear bits; asking for a rise, or writing while protected, fails.
  assign prog_bad = wp_ff || ((~mem_ff[BUS_ADDR[3:0]] & BUS_WDATA) != 32'h0000_0000);

  // The engine steps first, so a suspend landing on the last busy cycle finds it idle.
  always_comb begin
    nxt_mode  = mode_ff;
    nxt_stage = stage_ff;
    nxt_prog  = prog_ff;
    nxt_cnt   = cnt_ff;
    nxt_scnt  = scnt_ff;
    nxt_paddr = paddr_ff;
    nxt_pdata = pdata_ff;
    nxt_cfg   = cfg_ff;
    nxt_err   = err_ff;
    mem_we    = 1'b0;
    ev        = '0;
    case (prog_ff)
      fcq_pkg::FCQ_PRG_BUSY: begin
        if (cnt_ff <= 10'h001) begin
          mem_we   = 1'b1;
          nxt_prog = fcq_pkg::FCQ_PRG_IDLE;
          ev[`FCQ_EV_PROG_DONE] = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 10'h001;
        end
      end
      fcq_pkg::FCQ_PRG_SUSPENDING: begin
        if (scnt_ff <= 3'h1) begin
          nxt_prog = fcq_pkg::FCQ_PRG_SUSPENDED;
          ev[`FCQ_EV_SUSPENDED] = 1'b1;
        end else begin
          nxt_scnt = scnt_ff - 3'h1;
        end
      end
      default: begin
      end
    endcase
    if (BUS_WE) begin
      nxt_stage = fcq_pkg::FCQ_STG_NONE;
      if (stage_ff == fcq_pkg::FCQ_STG_PROG) begin
        nxt_mode = fcq_pkg::FCQ_MODE_STATUS;
        if (prog_bad) begin
          nxt_err = 1'b1;
          ev[`FCQ_EV_PROG_ERR] = 1'b1;
        end else begin
          nxt_prog  = fcq_pkg::FCQ_PRG_BUSY;
          nxt_cnt   = PROG_CYC;
          nxt_paddr = BUS_ADDR[3:0];
          nxt_pdata = BUS_WDATA;
        end
      end else if (stage_ff == fcq_pkg::FCQ_STG_CFG) begin
        nxt_mode = fcq_pkg::FCQ_MODE_ARRAY;
        if (cmd == `FCQ_CMD_CFG_CONFIRM) begin
          nxt_cfg = BUS_ADDR;
          ev[`FCQ_EV_CFG_LOADED] = 1'b1;
        end
      end else begin
        case (cmd)
          `FCQ_CMD_READ_ARRAY: nxt_mode = fcq_pkg::FCQ_MODE_ARRAY;
          `FCQ_CMD_READ_STATUS: nxt_mode = fcq_pkg::FCQ_MODE_STATUS;
          `FCQ_CMD_CLEAR_STATUS: nxt_err = 1'b0;
          `FCQ_CMD_PARAM_QUERY: nxt_mode = fcq_pkg::FCQ_MODE_QUERY;
          `FCQ_CMD_CFG_SETUP: nxt_stage = fcq_pkg::FCQ_STG_CFG;
          `FCQ_CMD_PROG_SETUP: begin
            // A pending error blocks new programs until status is cleared.
            if (nxt_prog == fcq_pkg::FCQ_PRG_IDLE && !err_ff) begin
              nxt_stage = fcq_pkg::FCQ_STG_PROG;
            end
          end
          `FCQ_CMD_SUSPEND: begin
            nxt_mode = fcq_pkg::FCQ_MODE_STATUS;
            if (nxt_prog == fcq_pkg::FCQ_PRG_BUSY) begin
              nxt_prog = fcq_pkg::FCQ_PRG_SUSPENDING;
              nxt_scnt = SUSP_CYC;
            end
          end
          `FCQ_CMD_RESUME: begin
            // Remaining count and captured word are untouched while parked.
            // Without a parked program the code is ignored, so array reads carry on.
            if (prog_ff == fcq_pkg::FCQ_PRG_SUSPENDED) begin
              nxt_mode = fcq_pkg::FCQ_MODE_STATUS;
              nxt_prog = fcq_pkg::FCQ_PRG_BUSY;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Command and engine state.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mode_ff  <= fcq_pkg::FCQ_MODE_ARRAY;
      stage_ff <= fcq_pkg::FCQ_STG_NONE;
      prog_ff  <= fcq_pkg::FCQ_PRG_IDLE;
      cnt_ff   <= 10'h000;
      scnt_ff  <= 3'h0;
      paddr_ff <= 4'h0;
      pdata_ff <= 32'h0000_0000;
      cfg_ff   <= `FCQ_CFG_RESET;
      err_ff   <= 1'b0;
    end else begin
      mode_ff  <= nxt_mode;
      stage_ff <= nxt_stage;
      prog_ff  <= nxt_prog;
      cnt_ff   <= nxt_cnt;
      scnt_ff  <= nxt_scnt;
      paddr_ff <= nxt_paddr;
      pdata_ff <= nxt_pdata;
      cfg_ff   <= nxt_cfg;
      err_ff   <= nxt_err;
    end
  end

  // Array starts erased; a finished program clears bits only.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 16; i++) begin
        mem_ff[i] <= 32'hFFFF_FFFF;
      end
    end else if (mem_we) begin
      mem_ff[paddr_ff] <= mem_ff[paddr_ff] & pdata_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register slave with events, mask and interrupt.

  logic        aw_ff;
  logic        w_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rdata_ff;
  logic [`FCQ_EV_WIDTH-1:0] sts_ff;
  logic [`FCQ_EV_WIDTH-1:0] mask_ff;
  logic        wr_go;
  logic        wr_ev;
  logic        wr_mask;
  logic        wr_ctrl;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] reg_rd;
  logic [`FCQ_EV_WIDTH-1:0] w1c;

  // Address and data are taken in either order; the write fires once both are held.
  assign S_AXI_AWREADY = !aw_ff;
  assign S_AXI_WREADY  = !w_ff;
  assign wr_go   = aw_ff && w_ff && !bvalid_ff;
  assign wr_ev   = wr_go && (awaddr_ff == `FCQ_REG_EVENTS) && wstrb_ff[0];
  assign wr_mask = wr_go && (awaddr_ff == `FCQ_REG_MASK) && wstrb_ff[0];
  assign wr_ctrl = wr_go && (awaddr_ff == `FCQ_REG_CTRL) && wstrb_ff[0];
  assign wr_hit  = (awaddr_ff == `FCQ_REG_EVENTS) || (awaddr_ff == `FCQ_REG_MASK) ||
                   (awaddr_ff == `FCQ_REG_CTRL);
  assign w1c     = wr_ev ? wdata_ff[`FCQ_EV_WIDTH-1:0] : '0;

  assign rd_hit = (S_AXI_ARADDR == `FCQ_REG_EVENTS) || (S_AXI_ARADDR == `FCQ_REG_MASK) ||
                  (S_AXI_ARADDR == `FCQ_REG_CONFIG) || (S_AXI_ARADDR == `FCQ_REG_STATE) ||
                  (S_AXI_ARADDR == `FCQ_REG_CTRL);
  assign reg_rd =
    (S_AXI_ARADDR == `FCQ_REG_EVENTS) ? {28'h000_0000, sts_ff} :
    (S_AXI_ARADDR == `FCQ_REG_MASK)   ? {28'h000_0000, mask_ff} :
    (S_AXI_ARADDR == `FCQ_REG_CONFIG) ? {16'h0000, cfg_ff} :
    (S_AXI_ARADDR == `FCQ_REG_STATE)  ? {18'h0_0000, prog_ff, mode_ff, stage_ff, flash_sts} :
    (S_AXI_ARADDR == `FCQ_REG_CTRL)   ? {31'h0000_0000, wp_ff} :
    32'h0000_0000;

  // Write channel capture and response.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `FCQ_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_ff) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= {S_AXI_AWADDR[11:2], 2'b00};
      end
      if (S_AXI_WVALID && !w_ff) begin
        w_ff     <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_ff     <= 1'b0;
        w_ff      <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? `FCQ_RESP_OKAY : `FCQ_RESP_DECERR;
      end else if (S_AXI_BREADY) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `FCQ_RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= reg_rd;
      rresp_ff  <= rd_hit ? `FCQ_RESP_OKAY : `FCQ_RESP_DECERR;
    end else if (S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Sticky events: a new event in the clearing cycle survives the clear.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sts_ff      <= '0;
      mask_ff     <= '0;
      wp_ff       <= 1'b0;
    end else begin
      sts_ff <= (sts_ff & ~w1c) | ev;
      if (wr_mask) begin
        mask_ff <= wdata_ff[`FCQ_EV_WIDTH-1:0];
      end
      if (wr_ctrl) begin
        wp_ff <= wdata_ff[0];
      end
    end
  end

  assign S_AXI_ARREADY = !rvalid_ff;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;
  assign IRQ           = |(sts_ff & mask_ff);

endmodule
`default_nettype wire

// file: sim/fcq_assertions.sv
// Concurrent checks on the command block ports, bound into the top module.
`timescale 1ns/1ns
`default_nettype none
module fcq_assertions (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        BUS_WE,
  input wire logic        BUS_RE,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [31:0] BUS_WDATA,
  input wire logic [31:0] BUS_RDATA,
  input wire logic        BUS_RVALID,
  input wire logic        SYNC_BURST
);
  ////////////////////////////////////////////////////////////////////////////////
  // Read mode left by the last write; a program data word is decoded like a command, by its low byte.
  wire logic [7:0] cmd = BUS_WDATA[7:0];
  logic            qry_ff;
  logic            stat_ff;
  wire logic       nxt_qry = BUS_WE ? (cmd == 8'h98) : qry_ff;
  wire logic       nxt_stat = BUS_WE ? (cmd == 8'h70 || cmd == 8'hB0) : stat_ff;

  // Mode trackers follow every command write.
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      qry_ff  <= 1'b0;
      stat_ff <= 1'b0;
    end else begin
      qry_ff  <= nxt_qry;
      stat_ff <= nxt_stat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // Setup write, the idle cycle the host leaves, then the confirm write.
  sequence cfg_pair;
    BUS_WE && cmd == 8'h60 ##1 !BUS_WE ##1 BUS_WE && cmd == 8'h03;
  endsequence

  // A read of one offset while query mode is in force.
  sequence qry_rd(logic [7:0] o);
    qry_ff && BUS_RE && BUS_ADDR[7:0] == o;
  endsequence

  rd_answer_a: assert property (BUS_RVALID == $past(BUS_RE))
    else $error("parallel read answer not one cycle after the request");
  status_byte_a: assert property (stat_ff && BUS_RE |=> BUS_RDATA[31:8] == 24'h00_0000)
    else $error("status read carries data above the low byte");
  cfg_load_a: assert property (cfg_pair |=> SYNC_BURST == !$past(BUS_ADDR[15]))
    else $error("burst mode does not follow the loaded bit 15");
  cfg_hold_a: assert property (!(BUS_WE && cmd == 8'h03) |=> $stable(SYNC_BURST))
    else $error("burst mode changed without a confirm write");
  qry_low_a: assert property (qry_ff && BUS_RE && BUS_ADDR[7:1] != 7'h00
    |=> BUS_RDATA[31:8] == 24'h00_0000)
    else $error("query byte not confined to the low data lines");
  qry_id_a: assert property (qry_ff && BUS_RE && BUS_ADDR[7:1] == 7'h00
    |=> BUS_RDATA[31:16] == 16'h0000)
    else $error("identification code wider than 16 bits");
  qry_idstr_a: assert property (qry_rd(8'h10) |=> BUS_RDATA == 32'h0000_0051)
    else $error("identification string not at offset 10h");
  qry_primary_a: assert property (qry_rd(8'h15) |=> BUS_RDATA == 32'h0000_0035)
    else $error("primary table pointer wrong");
  qry_alternate_a: assert property (qry_rd(8'h19) |=> BUS_RDATA == 32'h0000_0000)
    else $error("alternate table pointer wrong");
endmodule

bind fcq_top fcq_assertions u_fcq_assertions (
  .REF_CLK, .RST, .BUS_WE, .BUS_RE, .BUS_ADDR, .BUS_WDATA, .BUS_RDATA, .BUS_RVALID, .SYNC_BURST
);
`default_nettype wire

// file: sim/fcq_host_model.sv
// Host controller model that writes commands and reads words on the parallel bus.
`timescale 1ns/1ns
`default_nettype none
module fcq_host_model (
  input  wire logic        clk,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  output logic             we,
  output logic             re,
  output logic      [15:0] addr,
  output logic      [31:0] wdata
);
  // Idle bus at time zero.
  initial begin
    we    = 1'b0;
    re    = 1'b0;
    addr  = 16'h0000;
    wdata = 32'h0000_0000;
  end

  // One write; released lines show the inverse so a stale value is never trusted.
  task automatic wr(input logic [31:0] d, input logic [15:0] a);
    @(posedge clk);
    we    <= 1'b1;
    wdata <= d;
    addr  <= a;
    @(posedge clk);
    we    <= 1'b0;
    wdata <= ~d;
    addr  <= ~a;
  endtask

  // One read; the answer is due one cycle after the request edge.
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic ok);
    @(posedge clk);
    re   <= 1'b1;
    addr <= a;
    @(posedge clk);
    re   <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    ok = rvalid;
    d  = rdata;
  endtask

  // Poll status while the ready bit is low, with a bound against a hung engine.
  task automatic poll(output logic [31:0] s, output logic ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 300 && !ok; n++) begin
      rd(16'h0000, s, ok);
      ok = ok & (s[7] === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

// file: sim/fcq_top_tb_top.sv
// Self-checking bench for the flash command block.
`timescale 1ns/1ns
`default_nettype none
`include "fcq_consts.svh"
module fcq_top_tb_top;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            awv = 1'b0;
  logic            wv = 1'b0;
  logic            bready = 1'b0;
  logic            arv = 1'b0;
  logic            rready = 1'b0;
  logic     [11:0] awaddr = 12'h000;
  logic     [11:0] araddr = 12'h000;
  logic     [31:0] wdata = 32'h0000_0000;
  wire logic       awready, wready, bvalid, arready, rvalid, irq, sync, we, re, bvld;
  wire logic [1:0] bresp, rresp;
  wire logic[15:0] baddr;
  wire logic[31:0] rdata, bwdata, brdata;
  int              n_mismatch = 0;
  int              samples_checked = 0;
  logic      [7:0] qa [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h19};
  logic     [15:0] qd [8] = '{16'h00A5, 16'h1234, 16'h0051, 16'h0052, 16'h0059, 16'h0003,
                              16'h0035, 16'h0000};

  // Free-running 25 MHz clock.
  always #20 clk = ~clk;

  fcq_top uut (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .BUS_WE(we),
    .BUS_RE(re), .BUS_ADDR(baddr), .BUS_WDATA(bwdata), .BUS_RDATA(brdata),
    .BUS_RVALID(bvld), .SYNC_BURST(sync), .IRQ(irq));

  fcq_host_model h (.clk(clk), .rdata(brdata), .rvalid(bvld), .we(we), .re(re),
    .addr(baddr), .wdata(bwdata));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run; every path that stops the bench comes here.
  task automatic results;
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic stop;
    n_mismatch++;
    $display("Error at %0t: no answer within the wait limit", $time);
    results();
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    h.wr({24'h00_0000, c}, 16'h0000);
  endtask

  task automatic prog(input logic [15:0] a, input logic [31:0] d);
    cmd(8'h40);
    h.wr(d, a);
  endtask

  task automatic brd(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    h.rd(a, d, ok);
    if (ok !== 1'b1) stop();
    else chk(exp, d);
  endtask

  task automatic stat(input logic [31:0] exp);
    logic [31:0] s;
    logic        ok;
    h.poll(s, ok);
    if (ok !== 1'b1) stop();
    else chk(exp, s);
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata  <= d;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awv && awready === 1'b1) awv <= 1'b0;
      if (wv && wready === 1'b1) wv <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 50) stop();
    else chk({30'h0, er}, {30'h0, bresp});
  endtask

  task automatic axr(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arv && arready === 1'b1) arv <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 50) stop();
    else begin
      chk(exp, rdata);
      chk({30'h0, er}, {30'h0, rresp});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios run in order; each leaves the array contents the next one expects.
  initial begin
    int i;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'h0, {31'h0, sync});
    axr(`FCQ_REG_CONFIG, 32'h0000_FFFF, 2'b00);
    brd(16'h0003, 32'hFFFF_FFFF);
    $display("Test reset done");
    for (i = 0; i < 2; i++) begin
      cmd(8'h60);
      h.wr(32'h0000_0003, i ? 16'hFFFF : 16'h7FFF);
      @(posedge clk);
      chk({31'h0, i == 0}, {31'h0, sync});
      axr(`FCQ_REG_CONFIG, i ? 32'h0000_FFFF : 32'h0000_7FFF, 2'b00);
    end
    cmd(8'h60);
    h.wr(32'h0000_00FF, 16'h7FFF);
    axr(`FCQ_REG_CONFIG, 32'h0000_FFFF, 2'b00);
    brd(16'h0003, 32'hFFFF_FFFF);
    chk(32'h0, {31'h0, irq});
    axr(`FCQ_REG_EVENTS, 32'h0000_0008, 2'b00);
    axw(`FCQ_REG_MASK, 32'h0000_0008, 2'b00);
    chk(32'h1, {31'h0, irq});
    axw(`FCQ_REG_EVENTS, 32'h0000_0008, 2'b00);
    chk(32'h0, {31'h0, irq});
    axw(12'h020, 32'h0000_0001, 2'b11);
    axr(12'h020, 32'h0000_0000, 2'b11);
    $display("Test config and interrupt done");
    prog(16'h0002, 32'h0000_FF00);
    repeat (20) @(posedge clk);
    cmd(8'hB0);
    cmd(8'h70);
    stat(32'h0000_0084);
    axr(`FCQ_REG_STATE, 32'h0000_3484, 2'b00);
    cmd(8'hFF);
    brd(16'h0005, 32'hFFFF_FFFF);
    cmd(8'hD0);
    cmd(8'h70);
    stat(32'h0000_0080);
    cmd(8'hFF);
    brd(16'h0002, 32'h0000_FF00);
    axr(`FCQ_REG_EVENTS, 32'h0000_0003, 2'b00);
    prog(16'h0004, 32'h1234_5678);
    stat(32'h0000_0080);
    cmd(8'hB0);
    cmd(8'h70);
    stat(32'h0000_0080);
    cmd(8'hFF);
    brd(16'h0004, 32'h1234_5678);
    cmd(8'hD0);
    brd(16'h0004, 32'h1234_5678);
    $display("Test suspend done");
    prog(16'h0002, 32'hFFFF_FFFF);
    stat(32'h0000_0090);
    prog(16'h0006, 32'h0000_0000);
    cmd(8'h70);
    stat(32'h0000_0090);
    cmd(8'hFF);
    brd(16'h0006, 32'hFFFF_FFFF);
    cmd(8'h50);
    axw(`FCQ_REG_CTRL, 32'h0000_0001, 2'b00);
    prog(16'h0006, 32'h0000_0000);
    stat(32'h0000_0090);
    cmd(8'h50);
    axw(`FCQ_REG_CTRL, 32'h0000_0000, 2'b00);
    prog(16'h0006, 32'h0000_0000);
    stat(32'h0000_0080);
    $display("Test error done");
    cmd(8'h98);
    for (i = 0; i < 8; i++) brd({8'h00, qa[i]}, {16'h0000, qd[i]});
    cmd(8'hFF);
    brd(16'h0004, 32'h1234_5678);
    $display("Test query done");
    results();
  end
endmodule
`default_nettype wire
